/* output_step_sequencer.sv */
/*
  output step sequencer: step table over axi4-lite, live frequency, shape, phase and marker lines.
  assumes a single clock, synchronous inputs and an axi4-lite master with one write and one read at a time.
*/
// Operation
// [R1] - step frequency accepted from 1.0 to 550.0 hz in 0.1 hz units
// [R2] - frequency per step is fixed, kept from previous, or swept to reach target at end
// [R3] - each step picks sine, square or one of sixteen user shapes
// [R4] - shape either switches to the step's shape or keeps the previous one
// [R5] - step starts at programmed phase 0.0..359.9 degrees, or keeps the running phase
// [R6] - two marker lines carry bit 0 and bit 1 of the step's sync code
// [R7] - both marker lines read zero while the sequencer is idle
// [R8] - sync code is the step's own code or the previous step's code
// [R9] - each step has an end-phase enable and value; disabled means time alone ends it
// [R10] - at step end, proceed, go idle or go to hold as the step says
// [R11] - jump target zero moves to next step, 1..255 moves to that step
// [R12] - a jump is taken its programmed count 1..999 times; zero means forever
// [R13] - two trigger targets per step; zero disables, nonzero branches at once
// [R14] - edits to the running step's settings reach the live output at once
// [R15] - each step keeps its own jump counter; passes equal count plus one
// [R16] - with end phase enabled the step runs on until the phase point is reached
// [R17] - sync code is zero in the normal, non-sequence output state
// [R18] - step time 0.0001..999.9999 s in 0.1 ms units; step numbers 1..255
// [R19] - an exhausted jump counter reloads when execution falls through
// [R20] - a fixed 0.1 ms tick from the system clock times steps and sweeps
`timescale 1ns/1ps
module output_step_sequencer #(
  parameter int TICK_LEN = seq_pkg::TICK_CYCLES
) (
  input  logic                        CLK,
  input  logic                        RESET_N,
  input  logic                        CLK_EN,
  input  logic [seq_pkg::ADDR_W-1:0]  AWADDR,
  input  logic                        AWVALID,
  output logic                        AWREADY,
  input  logic [31:0]                 WDATA,
  input  logic [3:0]                  WSTRB,
  input  logic                        WVALID,
  output logic                        WREADY,
  output logic [1:0]                  BRESP,
  output logic                        BVALID,
  input  logic                        BREADY,
  input  logic [seq_pkg::ADDR_W-1:0]  ARADDR,
  input  logic                        ARVALID,
  output logic                        ARREADY,
  output logic [31:0]                 RDATA,
  output logic [1:0]                  RRESP,
  output logic                        RVALID,
  input  logic                        RREADY,
  output logic                        MARKER_LINE_LOW,
  output logic                        MARKER_LINE_HIGH,
  output logic [seq_pkg::STEP_FREQUENCY_W-1:0]  STEP_FREQUENCY,
  output logic [seq_pkg::SHAPE_W-1:0] WAVE_SHAPE,
  output logic [15:0]                 OUTPUT_PHASE,
  output logic [seq_pkg::STEP_W-1:0]  ACTIVE_STEP
);
  import seq_pkg::*;

  if (TICK_LEN < 2 || TICK_LEN > 4095) begin : g_bad
    $error("output_step_sequencer: TICK_LEN out of range");
  end

  typedef struct packed {
    seq_state_type     state;
    logic              fresh;
    logic [STEP_W-1:0] step;
    logic [TIME_W-1:0] elapsed;
    logic [11:0]       tick_cnt;
    logic              tick;
    logic [STEP_FREQUENCY_W-1:0] f0;
    logic [STEP_FREQUENCY_W-1:0] step_frequency;
    logic [SHAPE_W-1:0] wave;
    logic [1:0]        sync;
    logic [31:0]       acc;
    logic [STEP_W-1:0] edit;
    logic              awready;
    logic              wready;
    logic              aw_have;
    logic              w_have;
    logic              bvalid;
    logic [1:0]        bresp;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } state_type;

  state_type r, n;
  logic [1:0]  rst_pipe;
  logic        rst_n;
  logic [STEP_WORDS*32-1:0] row_cur, row_edit;
  logic [31:0] cur_w [STEP_WORDS];
  logic [31:0] edit_w [STEP_WORDS];
  logic [JCNT_W-1:0] jump_used [256];
  logic [4:0]  cmd;
  logic        mem_we, jc_we, jc_clr, go, fin;
  logic [JCNT_W-1:0] jc_val;
  logic [STEP_W-1:0] tgt;
  logic [3:0]  wkind, rkind;
  logic [2:0]  widx;
  logic [31:0] merged, inc, acc_adv, end_point;
  logic [TIME_W-1:0] tdiv;
  logic signed [38:0] sw_prod, sw_quot;
  logic [TIME_W-1:0] t_time;
  logic [STEP_FREQUENCY_W-1:0] t_step_frequency;
  logic [1:0]  t_fmode, t_sync, t_action;
  logic [SHAPE_W-1:0] t_shape;
  logic [PH_W-1:0] t_phase, t_endph;
  logic        t_wkeep, t_pkeep, t_skeep, t_enen;
  logic [STEP_W-1:0] t_jtgt, t_ba, t_bb;
  logic [JCNT_W-1:0] t_jcnt;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [3:0] decode_addr(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_STEP_BASE;
    if (a[1:0] != 2'h0) return K_NONE;
    if (a == OFS_CONTROL) return K_CONTROL;
    if (a == OFS_STATUS) return K_STATUS;
    if (a == OFS_EDIT) return K_EDIT;
    if (a == OFS_LIVE) return K_LIVE;
    if (a >= OFS_STEP_BASE && d < ADDR_W'(4 * STEP_WORDS)) return {1'b0, d[4:2]};
    return K_NONE;
  endfunction

  function automatic logic value_ok(input logic [2:0] w, input logic [31:0] v);
    case (w)
      3'(W_TIME): return v[TIME_W-1:0] >= TIME_MIN && v[TIME_W-1:0] <= TIME_MAX; // [R18]
      3'(W_STEP_FREQUENCY): return v[STEP_FREQUENCY_LSB +: STEP_FREQUENCY_W] >= STEP_FREQUENCY_MIN && v[STEP_FREQUENCY_LSB +: STEP_FREQUENCY_W] <= STEP_FREQUENCY_MAX
                         && v[FMODE_LSB +: 2] <= MODE_SWEEP; // [R1]
      3'(W_WAVE): return v[SHAPE_LSB +: SHAPE_W] <= USER_SHAPE_LAST && v[PHASE_LSB +: PH_W] <= PH_MAX; // [R3] [R5]
      3'(W_SYNC): return v[ENDPH_LSB +: PH_W] <= PH_MAX; // [R9]
      3'(W_END):  return v[ACT_LSB +: 2] <= ACT_HOLD && v[JCNT_LSB +: JCNT_W] <= JCNT_MAX; // [R12]
      default:    return 1'b1;
    endcase
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) m[b*8 +: 8] = nw[b*8 +: 8];
    end
    return m;
  endfunction

  // ****************************************
  // reset release and step table
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) rst_pipe <= 2'h0;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  step_store #(.STEPS(256), .WORDS(STEP_WORDS)) u_store (
    .clk       (CLK),
    .rst_n     (rst_n),
    .clk_en    (CLK_EN),
    .we        (mem_we),
    .wr_step   (r.edit),
    .wr_word   (widx),
    .wr_data   (merged),
    .rd_step_a (r.step),
    .rd_step_b (r.edit),
    .row_a     (row_cur),
    .row_b     (row_edit)
  );

  for (genvar g = 0; g < STEP_WORDS; g++) begin : g_words
    assign cur_w[g]  = row_cur[g*32 +: 32];
    assign edit_w[g] = row_edit[g*32 +: 32];
  end

  // live fields of the running step, read straight from the table [R14]
  assign t_time   = cur_w[W_TIME][TIME_W-1:0];
  assign t_step_frequency   = cur_w[W_STEP_FREQUENCY][STEP_FREQUENCY_LSB +: STEP_FREQUENCY_W];
  assign t_fmode  = cur_w[W_STEP_FREQUENCY][FMODE_LSB +: 2];
  assign t_shape  = cur_w[W_WAVE][SHAPE_LSB +: SHAPE_W];
  assign t_wkeep  = cur_w[W_WAVE][WKEEP_BIT];
  assign t_phase  = cur_w[W_WAVE][PHASE_LSB +: PH_W];
  assign t_pkeep  = cur_w[W_WAVE][PKEEP_BIT];
  assign t_sync   = cur_w[W_SYNC][SYNC_LSB +: 2];
  assign t_skeep  = cur_w[W_SYNC][SKEEP_BIT];
  assign t_endph  = cur_w[W_SYNC][ENDPH_LSB +: PH_W];
  assign t_enen   = cur_w[W_SYNC][ENEN_BIT];
  assign t_action = cur_w[W_END][ACT_LSB +: 2];
  assign t_jtgt   = cur_w[W_END][JTGT_LSB +: STEP_W];
  assign t_jcnt   = cur_w[W_END][JCNT_LSB +: JCNT_W];
  assign t_ba     = cur_w[W_BRANCH][BA_LSB +: STEP_W];
  assign t_bb     = cur_w[W_BRANCH][BB_LSB +: STEP_W];

  assign wkind     = decode_addr(r.awaddr);
  assign rkind     = decode_addr(ARADDR);
  assign widx      = (wkind < 4'(STEP_WORDS)) ? wkind[2:0] : 3'h0;
  assign merged    = merge_bytes(edit_w[widx], r.wdata, r.wstrb) & STEP_WORD_MASK[widx];
  assign inc       = 32'(r.step_frequency * PHASE_INC_PER_DHZ);
  assign acc_adv   = r.acc + inc;
  assign end_point = 32'(t_endph * PHASE_PER_DDEG);
  assign tdiv      = (t_time == '0) ? TIME_MIN : t_time;
  assign sw_prod   = 39'($signed({1'b0, t_step_frequency}) - $signed({1'b0, r.f0})) * 39'($signed({1'b0, r.elapsed}));
  assign sw_quot   = sw_prod / $signed({15'h0, tdiv}); // [R2]

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    cmd = 5'h00;
    mem_we = 1'b0;
    jc_we = 1'b0;
    jc_clr = 1'b0;
    jc_val = '0;
    go = 1'b0;
    fin = 1'b0;
    tgt = '0;
    n.tick = (r.tick_cnt == 12'(TICK_LEN - 1)); // [R20]
    n.tick_cnt = n.tick ? 12'h000 : r.tick_cnt + 12'h001;
    if (r.tick) n.acc = acc_adv;
    // write channels
    n.awready = AWVALID && !r.awready && !r.aw_have && !r.bvalid;
    n.wready = WVALID && !r.wready && !r.w_have && !r.bvalid;
    if (AWVALID && r.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = AWADDR;
    end
    if (WVALID && r.wready) begin
      n.w_have = 1'b1;
      n.wdata = WDATA;
      n.wstrb = WSTRB;
    end
    if (r.aw_have && r.w_have && !r.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (wkind)
        K_CONTROL: if (r.wstrb[0]) cmd = r.wdata[4:0];
        K_EDIT: if (r.wstrb[0]) n.edit = r.wdata[STEP_W-1:0];
        K_STATUS, K_LIVE, K_NONE: n.bresp = RESP_SLVERR;
        default: begin
          if (r.edit != '0 && value_ok(widx, merged)) mem_we = 1'b1; // [R18]
          else n.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (r.bvalid && BREADY) n.bvalid = 1'b0;
    // read channels
    n.arready = ARVALID && !r.arready && !r.rvalid;
    if (ARVALID && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0000_0000;
      case (rkind)
        K_CONTROL: n.rdata = 32'h0000_0000;
        K_STATUS: begin
          n.rdata[ST_STATE_LSB +: 2] = r.state;
          n.rdata[ST_STEP_LSB +: STEP_W] = r.step;
          n.rdata[ST_SYNC_LSB +: 2] = r.sync;
        end
        K_EDIT: n.rdata[STEP_W-1:0] = r.edit;
        K_LIVE: begin
          n.rdata[LV_STEP_FREQUENCY_LSB +: STEP_FREQUENCY_W] = r.step_frequency;
          n.rdata[LV_SHAPE_LSB +: SHAPE_W] = r.wave;
        end
        K_NONE: n.rresp = RESP_SLVERR;
        default: n.rdata = edit_w[rkind[2:0]];
      endcase
    end
    if (r.rvalid && RREADY) n.rvalid = 1'b0;
    // step entry settles one cycle after the step number changes
    if (r.fresh) begin
      n.fresh = 1'b0;
      n.f0 = r.step_frequency; // [R2]
      n.elapsed = '0;
      if (!t_pkeep) n.acc = 32'(t_phase * PHASE_PER_DDEG); // [R5]
    end else if (r.state != ST_IDLE) begin
      if (!t_wkeep) n.wave = t_shape; // [R4] [R14]
      if (!t_skeep) n.sync = t_sync; // [R8] [R6]
      case (t_fmode)
        MODE_CONST: n.step_frequency = t_step_frequency; // [R2] [R14]
        MODE_SWEEP: n.step_frequency = STEP_FREQUENCY_W'(39'($signed({1'b0, r.f0})) + sw_quot); // [R2]
        default: n.step_frequency = r.step_frequency;
      endcase
      if (r.state == ST_RUN && r.tick) begin
        if (r.elapsed + TIME_W'(1) >= tdiv) begin
          n.elapsed = tdiv;
          if (t_enen) n.state = ST_WAIT_PHASE; // [R16]
          else fin = 1'b1; // [R9]
        end else begin
          n.elapsed = r.elapsed + TIME_W'(1); // [R20]
        end
      end
      if (r.state == ST_WAIT_PHASE && r.tick && (acc_adv - end_point) < inc) fin = 1'b1; // [R16]
    end
    // step end and jump
    if (fin) begin
      if (t_jtgt != '0 && (t_jcnt == '0 || jump_used[r.step] < t_jcnt)) begin
        tgt = t_jtgt; // [R11]
        jc_we = (t_jcnt != '0); // [R12] [R15]
        jc_val = jump_used[r.step] + JCNT_W'(1);
      end else begin
        tgt = r.step + STEP_W'(1); // [R11]
        jc_we = (t_jtgt != '0); // [R19]
      end
      go = (t_action != ACT_STOP) && (tgt != '0);
      n.state = !go ? ST_IDLE : (t_action == ACT_HOLD) ? ST_HOLD : ST_RUN; // [R10]
    end
    // commands
    if ((cmd[CMD_TRIG_A] && t_ba != '0) || (cmd[CMD_TRIG_B] && t_bb != '0)) begin
      if (r.state == ST_RUN || r.state == ST_WAIT_PHASE) begin
        tgt = (cmd[CMD_TRIG_A] && t_ba != '0) ? t_ba : t_bb; // [R13]
        go = 1'b1;
        jc_we = 1'b0;
        n.state = ST_RUN;
      end
    end
    if (cmd[CMD_START]) begin
      if (r.state == ST_IDLE) begin
        tgt = FIRST_STEP;
        go = 1'b1;
        jc_clr = 1'b1;
        n.state = ST_RUN;
      end else if (r.state == ST_HOLD) begin
        n.state = ST_RUN;
      end
    end
    if (cmd[CMD_HOLD] && (n.state == ST_RUN || n.state == ST_WAIT_PHASE)) n.state = ST_HOLD;
    if (cmd[CMD_STOP]) begin
      n.state = ST_IDLE;
      go = 1'b0;
    end
    if (go) begin
      n.step = tgt;
      n.fresh = 1'b1;
      n.elapsed = '0;
    end
    if (n.state == ST_IDLE) begin
      n.sync = 2'h0; // [R7] [R17]
      n.fresh = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.step_frequency <= STEP_FREQUENCY_MIN;
      r.edit <= FIRST_STEP;
    end else if (CLK_EN) begin
      r <= n;
    end
  end

  // per-step jump counters [R15]
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) jump_used[i] <= '0;
    end else if (CLK_EN) begin
      if (jc_clr) begin
        for (int i = 0; i < 256; i++) jump_used[i] <= '0;
      end else if (jc_we) begin
        jump_used[r.step] <= jc_val; // [R19]
      end
    end
  end

  assign AWREADY = r.awready;
  assign WREADY = r.wready;
  assign BRESP = r.bresp;
  assign BVALID = r.bvalid;
  assign ARREADY = r.arready;
  assign RDATA = r.rdata;
  assign RRESP = r.rresp;
  assign RVALID = r.rvalid;
  assign MARKER_LINE_LOW = r.sync[0];
  assign MARKER_LINE_HIGH = r.sync[1];
  assign STEP_FREQUENCY = r.step_frequency;
  assign WAVE_SHAPE = r.wave;
  assign OUTPUT_PHASE = r.acc[31:16];
  assign ACTIVE_STEP = r.step;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_idle_sync_zero: assert property (r.state == ST_IDLE |-> !MARKER_LINE_LOW && !MARKER_LINE_HIGH) // [R7]
    else $error("marker lines not zero while idle");
  a_tick_spacing: assert property (CLK_EN && r.tick |-> r.tick_cnt == 12'h000) // [R20]
    else $error("tick out of step with its counter");
  a_const_step_frequency: assert property (CLK_EN && r.state == ST_RUN && !r.fresh && t_fmode == MODE_CONST
                                 |=> STEP_FREQUENCY == $past(t_step_frequency)) // [R14]
    else $error("fixed frequency not applied");
  a_keep_step_frequency: assert property (CLK_EN && r.state == ST_RUN && !r.fresh && t_fmode == MODE_KEEP
                                |=> STEP_FREQUENCY == $past(STEP_FREQUENCY)) // [R2]
    else $error("kept frequency changed");
  a_branch_take: assert property (CLK_EN && r.state == ST_RUN && cmd[CMD_TRIG_A] && t_ba != '0
                                  && cmd[CMD_HOLD:CMD_STOP] == 2'h0 |=> ACTIVE_STEP == $past(t_ba) && r.fresh) // [R13]
    else $error("trigger branch not taken");
  a_jump_step: assert property (CLK_EN && fin && t_action == PROCEED_ACTION && t_jtgt == '0 && r.step != 8'hff
                                && cmd == 5'h00 |=> ACTIVE_STEP == $past(r.step) + 8'h01) // [R11]
    else $error("step did not advance");
  a_stop_action: assert property (CLK_EN && fin && t_action == ACT_STOP && cmd == 5'h00 |=> r.state == ST_IDLE) // [R10]
    else $error("stop action did not idle");
  a_end_phase_wait: assert property (CLK_EN && r.state == ST_RUN && r.tick && !r.fresh && t_enen
                                     && r.elapsed + 24'h1 >= tdiv && cmd == 5'h00 |=> r.state == ST_WAIT_PHASE) // [R16]
    else $error("end phase wait not entered");
  a_sync_const: assert property (CLK_EN && r.state == ST_RUN && !r.fresh && !t_skeep && cmd == 5'h00 && !fin
                                 |=> {MARKER_LINE_HIGH, MARKER_LINE_LOW} == $past(t_sync)) // [R6]
    else $error("sync code not on marker lines");
  a_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped");
  a_read_answer: assert property (CLK_EN && ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");

  c_sweep: cover property (r.state == ST_RUN && t_fmode == MODE_SWEEP && r.tick);
  c_phase_wait: cover property (r.state == ST_WAIT_PHASE ##1 r.state == ST_RUN);
  c_branch: cover property (go && cmd[CMD_TRIG_B]);
  c_hold_action: cover property (fin && t_action == ACT_HOLD);
endmodule

/* seq_pkg.sv */
/*
  shared constants, encodings and types of the output step sequencer.
  assumes a 25 mhz system clock and an axi4-lite register bus with 32-bit data.
*/
package seq_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 100000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // widths and ranges
  // ****************************************
  localparam int STEP_W  = 8;
  localparam int STEP_FREQUENCY_W  = 13;
  localparam int PH_W    = 12;
  localparam int TIME_W  = 24;
  localparam int JCNT_W  = 10;
  localparam int SHAPE_W = 5;
  localparam int ADDR_W  = 8;
  localparam int STEP_WORDS = 6;
  localparam logic [STEP_FREQUENCY_W-1:0]  STEP_FREQUENCY_MIN  = 13'd10;
  localparam logic [STEP_FREQUENCY_W-1:0]  STEP_FREQUENCY_MAX  = 13'd5500;
  localparam logic [PH_W-1:0]    PH_MAX    = 12'd3599;
  localparam logic [TIME_W-1:0]  TIME_MIN  = 24'd1;
  localparam logic [TIME_W-1:0]  TIME_MAX  = 24'd9999999;
  localparam logic [JCNT_W-1:0]  JCNT_MAX  = 10'd999;
  localparam logic [SHAPE_W-1:0] SINE_SHAPE       = 5'd0;
  localparam logic [SHAPE_W-1:0] SQUARE_SHAPE     = 5'd1;
  localparam logic [SHAPE_W-1:0] USER_SHAPE_FIRST = 5'd2;
  localparam logic [SHAPE_W-1:0] USER_SHAPE_LAST  = 5'd17;
  localparam logic [STEP_W-1:0]  FIRST_STEP = 8'h01;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CONTROL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EDIT      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LIVE      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STEP_BASE = 8'h20;
  localparam logic [3:0] K_CONTROL = 4'h8;
  localparam logic [3:0] K_STATUS  = 4'h9;
  localparam logic [3:0] K_EDIT    = 4'ha;
  localparam logic [3:0] K_LIVE    = 4'hb;
  localparam logic [3:0] K_NONE    = 4'hf;
  localparam int W_TIME = 0, W_STEP_FREQUENCY = 1, W_WAVE = 2, W_SYNC = 3, W_END = 4, W_BRANCH = 5;
  // ****************************************
  // field positions
  // ****************************************
  localparam int STEP_FREQUENCY_LSB = 0, FMODE_LSB = 16;
  localparam int SHAPE_LSB = 0, WKEEP_BIT = 8, PHASE_LSB = 16, PKEEP_BIT = 31;
  localparam int SYNC_LSB = 0, SKEEP_BIT = 8, ENDPH_LSB = 16, ENEN_BIT = 31;
  localparam int ACT_LSB = 0, JTGT_LSB = 8, JCNT_LSB = 16;
  localparam int BA_LSB = 0, BB_LSB = 8;
  localparam int CMD_START = 0, CMD_STOP = 1, CMD_HOLD = 2, CMD_TRIG_A = 3, CMD_TRIG_B = 4;
  localparam int ST_STATE_LSB = 0, ST_STEP_LSB = 8, ST_SYNC_LSB = 16;
  localparam int LV_STEP_FREQUENCY_LSB = 0, LV_SHAPE_LSB = 16;
  localparam logic [5:0][31:0] STEP_WORD_MASK = {32'h0000ffff, 32'h03ffff03, 32'h8fff0103,
                                                 32'h8fff011f, 32'h00031fff, 32'h00ffffff};
  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] MODE_CONST = 2'h0, MODE_KEEP = 2'h1, MODE_SWEEP = 2'h2;
  localparam logic [1:0] PROCEED_ACTION = 2'h0, ACT_STOP = 2'h1, ACT_HOLD = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
  localparam logic [31:0] PHASE_INC_PER_DHZ = 32'd42950;
  localparam logic [31:0] PHASE_PER_DDEG    = 32'd1193046;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD, ST_WAIT_PHASE} seq_state_type;
endpackage

/* step_store.sv */
/*
  step table: one row of words per step number, one write port, two row read ports.
  assumes the writer has already masked and range-checked the word.
*/
`timescale 1ns/1ps
module step_store #(
  parameter int STEPS = 256,
  parameter int WORDS = 6
) (
  input  logic                 clk,
  input  logic                 rst_n,
  input  logic                 clk_en,
  input  logic                 we,
  input  logic [7:0]           wr_step,
  input  logic [2:0]           wr_word,
  input  logic [31:0]          wr_data,
  input  logic [7:0]           rd_step_a,
  input  logic [7:0]           rd_step_b,
  output logic [WORDS*32-1:0]  row_a,
  output logic [WORDS*32-1:0]  row_b
);
  logic [31:0] mem [STEPS][WORDS];

  if (STEPS > 256 || STEPS < 2 || WORDS > 8 || WORDS < 1) begin : g_bad
    $error("step_store: unsupported STEPS or WORDS");
  end

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < STEPS; s++) begin
        for (int w = 0; w < WORDS; w++) begin
          mem[s][w] <= 32'h0000_0000;
        end
      end
    end else if (clk_en && we) begin
      mem[wr_step][wr_word] <= wr_data;
    end
  end

  for (genvar g = 0; g < WORDS; g++) begin : g_rd
    assign row_a[g*32 +: 32] = mem[rd_step_a][g];
    assign row_b[g*32 +: 32] = mem[rd_step_b][g];
  end
endmodule

/* host_model.sv */
/*
  host model: axi4-lite master writing and reading step settings.
  assumes the bench bounds every wait with one overall cycle limit.
*/
`timescale 1ns/1ps
module host_model (
  input  logic        CLK,
  output logic [7:0]  AWADDR,
  output logic        AWVALID,
  input  logic        AWREADY,
  output logic [31:0] WDATA,
  output logic [3:0]  WSTRB,
  output logic        WVALID,
  input  logic        WREADY,
  input  logic [1:0]  BRESP,
  input  logic        BVALID,
  output logic        BREADY,
  output logic [7:0]  ARADDR,
  output logic        ARVALID,
  input  logic        ARREADY,
  input  logic [31:0] RDATA,
  input  logic [1:0]  RRESP,
  input  logic        RVALID,
  output logic        RREADY
);
  initial {AWADDR, AWVALID, WDATA, WSTRB, WVALID, BREADY, ARADDR, ARVALID, RREADY} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    {AWADDR, WDATA, WSTRB} <= {a, v, 4'hf};
    {AWVALID, WVALID, BREADY} <= 3'h7;
    do begin
      @(posedge CLK);
      AWVALID <= AWVALID && !AWREADY;
      WVALID <= WVALID && !WREADY;
    end while ((AWVALID && !AWREADY) || (WVALID && !WREADY));
    do @(posedge CLK); while (!BVALID);
    r = BRESP;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (!RVALID);
    {v, r} = {RDATA, RRESP};
  endtask
endmodule

/* test_output_step_sequencer.sv */
/*
  testbench of the output step sequencer: register access and a short run.
  assumes host_model as bus master and a shortened tick.
*/
`timescale 1ns/1ps
module test_output_step_sequencer;
  import seq_pkg::*;
  logic CLK = 0, RESET_N = 0;
  logic [7:0] AWADDR, ARADDR, ACTIVE_STEP;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, r;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic MARKER_LINE_LOW, MARKER_LINE_HIGH;
  logic [STEP_FREQUENCY_W-1:0] STEP_FREQUENCY;
  logic [SHAPE_W-1:0] WAVE_SHAPE;
  logic [15:0] OUTPUT_PHASE;
  int n_errors = 0, tests_run = 0, cycles = 0;
  always #20 CLK = ~CLK;
  output_step_sequencer #(.TICK_LEN(20)) uut (.CLK(CLK), .RESET_N(RESET_N), .CLK_EN(1'b1),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .MARKER_LINE_LOW(MARKER_LINE_LOW),
    .MARKER_LINE_HIGH(MARKER_LINE_HIGH), .STEP_FREQUENCY(STEP_FREQUENCY),
    .WAVE_SHAPE(WAVE_SHAPE), .OUTPUT_PHASE(OUTPUT_PHASE), .ACTIVE_STEP(ACTIVE_STEP));
  host_model host (.CLK(CLK), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
  function automatic logic [7:0] sa(input int w);
    return OFS_STEP_BASE + 8'(4 * w);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d, compares %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic t_regs;
    host.rd(OFS_EDIT, d, r);
    check(d, 32'h1);
    host.rd(8'h10, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    check(32'({MARKER_LINE_HIGH, MARKER_LINE_LOW}), 32'h0);
    host.wr(sa(W_STEP_FREQUENCY), 32'd5501, r);
    check(32'(r), 32'(RESP_SLVERR));
    host.wr(sa(W_STEP_FREQUENCY), 32'd9, r);
    check(32'(r), 32'(RESP_SLVERR));
    host.wr(sa(W_STEP_FREQUENCY), 32'd5500, r);
    check(32'(r), 32'(RESP_OKAY));
  endtask
  task automatic t_run;
    host.wr(sa(W_TIME), 32'h3, r);
    host.wr(sa(W_STEP_FREQUENCY), 32'd100, r);
    host.wr(sa(W_WAVE), 32'h0708_0001, r);
    host.wr(sa(W_SYNC), 32'h2, r);
    host.wr(sa(W_END), 32'(ACT_STOP), r);
    host.wr(OFS_CONTROL, 32'h1, r);
    repeat (4) @(posedge CLK);
    check(32'(ACTIVE_STEP), 32'h1);
    check(32'(OUTPUT_PHASE - 16'((32'd1800 * PHASE_PER_DDEG) >> 16) < 16'h0043), 32'h1);
    check(32'(STEP_FREQUENCY), 32'd100);
    check(32'(WAVE_SHAPE), 32'(SQUARE_SHAPE));
    check(32'({MARKER_LINE_HIGH, MARKER_LINE_LOW}), 32'h2);
    host.wr(sa(W_STEP_FREQUENCY), 32'd200, r);
    repeat (2) @(posedge CLK);
    check(32'(STEP_FREQUENCY), 32'd200);
    repeat (100) @(posedge CLK);
    check(32'({MARKER_LINE_HIGH, MARKER_LINE_LOW}), 32'h0);
    host.rd(OFS_STATUS, d, r);
    check(32'(d[1:0]), 32'h0);
  endtask
  task automatic t_loop;
    host.wr(sa(W_END), 32'h0, r);
    host.wr(OFS_EDIT, 32'h2, r);
    host.wr(sa(W_TIME), 32'h1, r);
    host.wr(sa(W_END), 32'h0001_0202, r);
    host.wr(OFS_EDIT, 32'h3, r);
    host.wr(sa(W_TIME), 32'd1000, r);
    host.wr(sa(W_BRANCH), 32'h1, r);
    host.wr(OFS_CONTROL, 32'h1, r);
    repeat (150) @(posedge CLK);
    check(32'(ACTIVE_STEP), 32'h2);
    host.rd(OFS_STATUS, d, r);
    check(32'(d[1:0]), 32'h2);
    host.wr(OFS_CONTROL, 32'h1, r);
    repeat (50) @(posedge CLK);
    check(32'(ACTIVE_STEP), 32'h3);
    host.wr(OFS_CONTROL, 32'h1, r);
    host.wr(OFS_CONTROL, 32'h8, r);
    repeat (2) @(posedge CLK);
    check(32'(ACTIVE_STEP), 32'h1);
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_regs();
    t_run();
    t_loop();
    end_sim();
  end
endmodule
